//--- include/bsfc_defines.svh
// Offsets, fields, reset values, command codes and timing of the flash host
`ifndef BSFC_DEFINES_SVH
`define BSFC_DEFINES_SVH
`define BSFC_CLK_MHZ     125
`define BSFC_CYC(ns)     ((((ns) * `BSFC_CLK_MHZ) + 999) / 1000)
`define BSFC_SETUP_NS    30
`define BSFC_STROBE_NS   70
`define BSFC_HOLD_NS     20
`define BSFC_BUSY_NS     90
`define BSFC_OFF_CTRL    8'h00
`define BSFC_OFF_ADDR    8'h04
`define BSFC_OFF_DATA    8'h08
`define BSFC_OFF_STAT    8'h0c
`define BSFC_CTRL_GO     0
`define BSFC_CTRL_OP     1
`define BSFC_CTRL_WAIT   4
`define BSFC_CTRL_WORD   5
`define BSFC_CTRL_STBY   6
`define BSFC_CTRL_HWRST  7
`define BSFC_CTRL_POLL   8
`define BSFC_CTRL_RST    9'h020
`define BSFC_CTRL_MASK   9'h1fe
`define BSFC_STAT_BUSY   0
`define BSFC_STAT_RDY    1
`define BSFC_STAT_BYP    2
`define BSFC_STAT_DONE   3
`define BSFC_STAT_RDATA  16
`define BSFC_UNLK1_A     20'h00aaa
`define BSFC_UNLK2_W     20'h00554
`define BSFC_UNLK2_B     20'h00555
`define BSFC_CMD_UNLK1   8'haa
`define BSFC_CMD_UNLK2   8'h55
`define BSFC_CMD_PROG    8'ha0
`define BSFC_CMD_ERASE   8'h80
`define BSFC_CMD_SECTOR  8'h30
`define BSFC_CMD_CHIP    8'h10
`define BSFC_CMD_SUSP    8'hb0
`define BSFC_CMD_RESUME  8'h30
`define BSFC_CMD_BYP_ON  8'h20
`define BSFC_CMD_BYP_X1  8'h90
`define BSFC_CMD_BYP_X2  8'h00
`endif

//--- include/bsfc_pkg.sv
// Types shared by the flash host controller modules
package bsfc_pkg;
	typedef enum logic [2:0] {
		OP_READ, OP_PROG, OP_SERASE, OP_CERASE,
		OP_SUSP, OP_RESUME, OP_BYP_ON, OP_BYP_OFF
	} bsfc_op_t;
	typedef enum logic [2:0] {
		S_IDLE, S_ISSUE, S_SETTLE, S_WPIN, S_POLLA, S_POLLB
	} bsfc_st_t;
	typedef enum logic [1:0] {
		C_IDLE, C_SETUP, C_STROBE, C_HOLD
	} bsfc_cyc_st_t;
endpackage

//--- include/bsfc_cyc_if.sv
// Request and answer of one flash bus cycle between sequencer and pin engine
`timescale 1ns/1ps
interface bsfc_cyc_if;
	logic        reqValid;
	logic        reqWrite;
	logic [19:0] reqAddr;
	logic [15:0] reqData;
	logic        wordMode;
	logic        standby;
	logic        ack;
	logic [15:0] rdData;
	modport ctl (output reqValid, reqWrite, reqAddr, reqData, wordMode,
		standby, input ack, rdData);
	modport cyc (input reqValid, reqWrite, reqAddr, reqData, wordMode,
		standby, output ack, rdData);
endinterface

//--- rtl/bsfc_cycle.sv
// Pin engine: one timed read or write cycle on the flash pins
`timescale 1ns/1ps
`include "bsfc_defines.svh"
module bsfc_cycle (
	input  logic        sys_clk,
	input  logic        reset,
	bsfc_cyc_if.cyc     cyc,
	output logic        flashCeN,
	output logic        flashOeN,
	output logic        flashWeN,
	output logic [18:0] flashAddr,
	output logic [15:0] dataBusOut,
	output logic [15:0] dataBusOeN,
	input  logic [15:0] dataBusIn
);
	import bsfc_pkg::*;
	localparam logic [3:0] SETUP_C  = 4'(`BSFC_CYC(`BSFC_SETUP_NS) - 1);
	localparam logic [3:0] STROBE_C = 4'(`BSFC_CYC(`BSFC_STROBE_NS) - 1);
	localparam logic [3:0] HOLD_C   = 4'(`BSFC_CYC(`BSFC_HOLD_NS) - 1);

	bsfc_cyc_st_t st_ff;
	logic [3:0]   tmr_ff;
	logic         wr_ff;
	logic [15:0]  dqS1_ff, dqS2_ff, dqS3_ff;
	logic         take, tmrDone, dataSteady, dataMsbOrLowAddr;

	// ----------------------------------------
	// Cycle sequencing
	// ----------------------------------------
	// The ack cycle itself is skipped so a held request is not taken twice
	assign take       = cyc.reqValid && !cyc.ack;
	assign tmrDone    = (tmr_ff == 4'h0);
	assign dataSteady = wr_ff || (dqS2_ff == dqS3_ff);
	// Byte mode turns the top data line into the lowest address bit
	assign dataMsbOrLowAddr = cyc.wordMode ? cyc.reqData[15] : cyc.reqAddr[0];

	// State and phase timer
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			st_ff  <= C_IDLE;
			tmr_ff <= 4'h0;
		end else begin
			unique case (st_ff)
				C_IDLE: if (take) begin
					st_ff  <= C_SETUP;
					tmr_ff <= SETUP_C;
				end
				C_SETUP: if (tmrDone) begin
					st_ff  <= C_STROBE;
					tmr_ff <= STROBE_C;
				end else tmr_ff <= tmr_ff - 4'h1;
				C_STROBE: if (tmrDone && dataSteady) begin
					st_ff  <= C_HOLD;
					tmr_ff <= HOLD_C;
				end else if (!tmrDone) tmr_ff <= tmr_ff - 4'h1;
				C_HOLD: if (tmrDone) st_ff <= C_IDLE;
				else tmr_ff <= tmr_ff - 4'h1;
			endcase
		end
	end

	// Read data pass three flops; capture waits until two stages agree
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			dqS1_ff <= 16'h0000;
			dqS2_ff <= 16'h0000;
			dqS3_ff <= 16'h0000;
		end else begin
			dqS1_ff <= dataBusIn;
			dqS2_ff <= dqS1_ff;
			dqS3_ff <= dqS2_ff;
		end
	end

	// ----------------------------------------
	// Pin drive
	// ----------------------------------------
	// Chip select, gate and strobe are separate so outputs never fight
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			flashCeN   <= 1'b1;
			flashOeN   <= 1'b1;
			flashWeN   <= 1'b1;
			flashAddr  <= 19'h00000;
			dataBusOut <= 16'h0000;
			dataBusOeN <= 16'hffff;
			wr_ff      <= 1'b0;
			cyc.ack    <= 1'b0;
			cyc.rdData <= 16'h0000;
		end else begin
			cyc.ack <= 1'b0;
			unique case (st_ff)
				C_IDLE: begin
					flashCeN <= cyc.standby;
					if (take) begin
						flashCeN   <= 1'b0;
						flashAddr  <= cyc.reqAddr[19:1];
						wr_ff      <= cyc.reqWrite;
						dataBusOut <= {dataMsbOrLowAddr, cyc.reqData[14:0]};
						dataBusOeN <= cyc.wordMode ? {16{!cyc.reqWrite}} :
							{1'b0, 7'h7f, {8{!cyc.reqWrite}}};
					end
				end
				C_SETUP: if (tmrDone) begin
					flashWeN <= !wr_ff;
					flashOeN <= wr_ff;
				end
				C_STROBE: if (tmrDone && dataSteady) begin
					flashWeN <= 1'b1;
					flashOeN <= 1'b1;
					if (!wr_ff) cyc.rdData <= dqS3_ff;
				end
				C_HOLD: if (tmrDone) begin
					cyc.ack    <= 1'b1;
					dataBusOeN <= 16'hffff;
				end
			endcase
		end
	end

	property p_write_form;
		@(posedge sys_clk) disable iff (reset)
		!flashWeN |-> (!flashCeN && flashOeN && dataBusOeN[7:0] == 8'h00);
	endproperty
	a_write_form: assert property (p_write_form)
		else $error("write strobe without select or with gate open");

	property p_read_form;
		@(posedge sys_clk) disable iff (reset)
		!flashOeN |-> (!flashCeN && flashWeN && (&dataBusOeN[7:0]));
	endproperty
	a_read_form: assert property (p_read_form)
		else $error("read gate open while strobing or driving data");

	property p_standby;
		@(posedge sys_clk) disable iff (reset)
		(st_ff == C_IDLE && cyc.standby && !cyc.reqValid)[*2] |-> flashCeN;
	endproperty
	a_standby: assert property (p_standby)
		else $error("select held low in standby");
endmodule

//--- rtl/bsfc_ctrl.sv
// Host controller for a parallel boot-sector flash, AXI4-Lite command port
`timescale 1ns/1ps
`include "bsfc_defines.svh"
// Function
// - Commands go out as plain write cycles latched by the device.
// - In bypass mode a program takes two writes instead of four.
// - Completion seen on ready pin or polling of the toggle status bit.
// - Erase may be suspended, other sectors used, then resumed.
// - Host may place device in standby by its pins.
// - Host reads with select and gate low, strobe high.
module bsfc_ctrl #(
	parameter int AXI_AW = 8
) (
	input  logic              sys_clk,
	input  logic              reset,
	input  logic [AXI_AW-1:0] s_axi_awaddr,
	input  logic              s_axi_awvalid,
	output logic              s_axi_awready,
	input  logic [31:0]       s_axi_wdata,
	input  logic [3:0]        s_axi_wstrb,
	input  logic              s_axi_wvalid,
	output logic              s_axi_wready,
	output logic [1:0]        s_axi_bresp,
	output logic              s_axi_bvalid,
	input  logic              s_axi_bready,
	input  logic [AXI_AW-1:0] s_axi_araddr,
	input  logic              s_axi_arvalid,
	output logic              s_axi_arready,
	output logic [31:0]       s_axi_rdata,
	output logic [1:0]        s_axi_rresp,
	output logic              s_axi_rvalid,
	input  logic              s_axi_rready,
	output logic              flashCeN,
	output logic              flashOeN,
	output logic              flashWeN,
	output logic              flashResetN,
	output logic              flashWordSel,
	output logic [18:0]       flashAddr,
	output logic [15:0]       dataBusOut,
	output logic [15:0]       dataBusOeN,
	input  logic [15:0]       dataBus,
	input  logic              opDoneFlag
);
	import bsfc_pkg::*;
	localparam logic [7:0] BUSY_C = 8'(`BSFC_CYC(`BSFC_BUSY_NS) - 1);

	bsfc_cyc_if cyc ();

	logic         awready_ff, bvalid_ff, arready_ff, rvalid_ff;
	logic [1:0]   bresp_ff, rresp_ff;
	logic [31:0]  rdata_ff;
	logic [8:0]   ctrlReg_ff;
	logic [19:0]  addrReg_ff;
	logic [15:0]  dataReg_ff;
	logic         goPulse_ff, done_ff, busyDly_ff;
	logic         rdyS1_ff, rdyS2_ff, rdyS3_ff, rdyLvl_ff;
	bsfc_st_t     st_ff;
	logic [2:0]   step_ff, wrCnt_ff;
	logic [7:0]   tmr_ff;
	logic         busy_ff, byp_ff, tog_ff;
	logic [15:0]  rdData_ff;
	logic [31:0]  curWr, newWr, rdMux, statReg;
	logic [36:0]  seq;
	logic         wrHit, rdHit, doneClr;
	bsfc_op_t     op;

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	// Word-aligned match of a bus address against a register offset
	function automatic logic isOff(input logic [AXI_AW-1:0] a,
		input logic [7:0] off);
		isOff = (a[AXI_AW-1:2] == (AXI_AW-2)'(off[7:2]));
	endfunction

	function automatic logic [31:0] bmerge(input logic [31:0] old,
		input logic [31:0] nw, input logic [3:0] strb);
		for (int i = 0; i < 4; i++)
			bmerge[i*8 +: 8] = strb[i] ? nw[i*8 +: 8] : old[i*8 +: 8];
	endfunction

	function automatic logic [36:0] ent(input logic l, input logic [19:0] a,
		input logic [7:0] d);
		ent = {l, a, 8'h00, d};
	endfunction

	// Operations that start an embedded algorithm or stop one
	function automatic logic isLong(input bsfc_op_t o);
		isLong = (o == OP_PROG) || (o == OP_SERASE) || (o == OP_CERASE) ||
			(o == OP_SUSP);
	endfunction

	// Step table of every command sequence: {last, address, data}
	function automatic logic [36:0] seqStep(input bsfc_op_t o,
		input logic byp, input logic [2:0] s, input logic [19:0] a,
		input logic [15:0] d, input logic wm);
		logic [19:0] u2;
		u2 = wm ? `BSFC_UNLK2_W : `BSFC_UNLK2_B;
		seqStep = {1'b1, a, d};
		unique case (o)
			OP_READ: seqStep = {1'b1, a, 16'h0000};
			OP_PROG: begin
				if (byp) begin
					if (s == 3'd0) seqStep = ent(1'b0, `BSFC_UNLK1_A, `BSFC_CMD_PROG);
				end else begin
					unique case (s)
						3'd0: seqStep = ent(1'b0, `BSFC_UNLK1_A, `BSFC_CMD_UNLK1);
						3'd1: seqStep = ent(1'b0, u2, `BSFC_CMD_UNLK2);
						3'd2: seqStep = ent(1'b0, `BSFC_UNLK1_A, `BSFC_CMD_PROG);
						default: seqStep = {1'b1, a, d};
					endcase
				end
			end
			OP_SERASE, OP_CERASE: begin
				unique case (s)
					3'd0, 3'd3: seqStep = ent(1'b0, `BSFC_UNLK1_A, `BSFC_CMD_UNLK1);
					3'd1, 3'd4: seqStep = ent(1'b0, u2, `BSFC_CMD_UNLK2);
					3'd2: seqStep = ent(1'b0, `BSFC_UNLK1_A, `BSFC_CMD_ERASE);
					default: seqStep = (o == OP_SERASE) ?
						ent(1'b1, a, `BSFC_CMD_SECTOR) :
						ent(1'b1, `BSFC_UNLK1_A, `BSFC_CMD_CHIP);
				endcase
			end
			OP_SUSP:   seqStep = ent(1'b1, a, `BSFC_CMD_SUSP);
			OP_RESUME: seqStep = ent(1'b1, a, `BSFC_CMD_RESUME);
			OP_BYP_ON: begin
				unique case (s)
					3'd0: seqStep = ent(1'b0, `BSFC_UNLK1_A, `BSFC_CMD_UNLK1);
					3'd1: seqStep = ent(1'b0, u2, `BSFC_CMD_UNLK2);
					default: seqStep = ent(1'b1, `BSFC_UNLK1_A, `BSFC_CMD_BYP_ON);
				endcase
			end
			OP_BYP_OFF: seqStep = (s == 3'd0) ? ent(1'b0, a, `BSFC_CMD_BYP_X1) :
				ent(1'b1, a, `BSFC_CMD_BYP_X2);
		endcase
	endfunction

	assign op  = bsfc_op_t'(ctrlReg_ff[`BSFC_CTRL_OP +: 3]);
	assign seq = seqStep(op, byp_ff, step_ff, addrReg_ff, dataReg_ff,
		ctrlReg_ff[`BSFC_CTRL_WORD]);

	// ----------------------------------------
	// AXI4-Lite slave
	// ----------------------------------------
	assign s_axi_awready = awready_ff;
	assign s_axi_wready  = awready_ff;
	assign s_axi_bvalid  = bvalid_ff;
	assign s_axi_bresp   = bresp_ff;
	assign s_axi_arready = arready_ff;
	assign s_axi_rvalid  = rvalid_ff;
	assign s_axi_rresp   = rresp_ff;
	assign s_axi_rdata   = rdata_ff;

	// Decode of the writable words and the status word
	always_comb begin
		wrHit = isOff(s_axi_awaddr, `BSFC_OFF_CTRL) ||
			isOff(s_axi_awaddr, `BSFC_OFF_ADDR) ||
			isOff(s_axi_awaddr, `BSFC_OFF_DATA);
		curWr = 32'h0;
		if (isOff(s_axi_awaddr, `BSFC_OFF_CTRL)) curWr = {23'h0, ctrlReg_ff};
		if (isOff(s_axi_awaddr, `BSFC_OFF_ADDR)) curWr = {12'h0, addrReg_ff};
		if (isOff(s_axi_awaddr, `BSFC_OFF_DATA)) curWr = {16'h0, dataReg_ff};
		newWr = bmerge(curWr, s_axi_wdata, s_axi_wstrb);
		statReg = 32'h0;
		statReg[`BSFC_STAT_BUSY] = busy_ff;
		statReg[`BSFC_STAT_RDY]  = rdyLvl_ff;
		statReg[`BSFC_STAT_BYP]  = byp_ff;
		statReg[`BSFC_STAT_DONE] = done_ff;
		statReg[`BSFC_STAT_RDATA +: 16] = rdData_ff;
		rdHit = 1'b1;
		rdMux = 32'h0;
		if (isOff(s_axi_araddr, `BSFC_OFF_CTRL)) rdMux = {23'h0, ctrlReg_ff};
		else if (isOff(s_axi_araddr, `BSFC_OFF_ADDR)) rdMux = {12'h0, addrReg_ff};
		else if (isOff(s_axi_araddr, `BSFC_OFF_DATA)) rdMux = {16'h0, dataReg_ff};
		else if (isOff(s_axi_araddr, `BSFC_OFF_STAT)) rdMux = statReg;
		else rdHit = 1'b0;
	end

	// Ready waits for both channels, so no write is ever half taken
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			awready_ff <= 1'b0;
			bvalid_ff  <= 1'b0;
			bresp_ff   <= 2'h0;
			ctrlReg_ff <= `BSFC_CTRL_RST;
			addrReg_ff <= 20'h00000;
			dataReg_ff <= 16'h0000;
			goPulse_ff <= 1'b0;
		end else begin
			awready_ff <= s_axi_awvalid && s_axi_wvalid && !awready_ff && !bvalid_ff;
			goPulse_ff <= 1'b0;
			if (awready_ff) begin
				bvalid_ff <= 1'b1;
				bresp_ff  <= wrHit ? 2'h0 : 2'h2;
				if (isOff(s_axi_awaddr, `BSFC_OFF_CTRL)) begin
					// A start while busy is dropped; the other fields still land
					ctrlReg_ff <= newWr[8:0] & `BSFC_CTRL_MASK;
					goPulse_ff <= newWr[`BSFC_CTRL_GO] && !busy_ff;
				end
				if (isOff(s_axi_awaddr, `BSFC_OFF_ADDR)) addrReg_ff <= newWr[19:0];
				if (isOff(s_axi_awaddr, `BSFC_OFF_DATA)) dataReg_ff <= newWr[15:0];
			end else if (s_axi_bready) begin
				bvalid_ff <= 1'b0;
			end
		end
	end

	// Read channel, one beat at a time
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			arready_ff <= 1'b0;
			rvalid_ff  <= 1'b0;
			rresp_ff   <= 2'h0;
			rdata_ff   <= 32'h0;
		end else begin
			arready_ff <= s_axi_arvalid && !arready_ff && !rvalid_ff;
			if (arready_ff) begin
				rvalid_ff <= 1'b1;
				rdata_ff  <= rdMux;
				rresp_ff  <= rdHit ? 2'h0 : 2'h2;
			end else if (s_axi_rready) begin
				rvalid_ff <= 1'b0;
			end
		end
	end

	// Done is sticky; an end arriving with the clear still sets it
	assign doneClr = awready_ff && isOff(s_axi_awaddr, `BSFC_OFF_CTRL);
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			busyDly_ff <= 1'b0;
			done_ff    <= 1'b0;
		end else begin
			busyDly_ff <= busy_ff;
			done_ff    <= (busyDly_ff && !busy_ff) || (done_ff && !doneClr);
		end
	end

	// ----------------------------------------
	// Ready pin synchroniser and static pins
	// ----------------------------------------
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			rdyS1_ff  <= 1'b0;
			rdyS2_ff  <= 1'b0;
			rdyS3_ff  <= 1'b0;
			rdyLvl_ff <= 1'b0;
		end else begin
			rdyS1_ff <= opDoneFlag;
			rdyS2_ff <= rdyS1_ff;
			rdyS3_ff <= rdyS2_ff;
			if (rdyS2_ff == rdyS3_ff) rdyLvl_ff <= rdyS3_ff;
		end
	end

	// Reset pin and width select follow the control word
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			flashResetN  <= 1'b0;
			flashWordSel <= 1'b1;
			cyc.wordMode <= 1'b1;
			cyc.standby  <= 1'b0;
		end else begin
			flashResetN  <= !ctrlReg_ff[`BSFC_CTRL_HWRST];
			flashWordSel <= ctrlReg_ff[`BSFC_CTRL_WORD];
			cyc.wordMode <= ctrlReg_ff[`BSFC_CTRL_WORD];
			cyc.standby  <= ctrlReg_ff[`BSFC_CTRL_STBY] && !busy_ff;
		end
	end

	// ----------------------------------------
	// Command sequencer
	// ----------------------------------------
	// Erase and resume may run without waiting so a suspend can follow
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			st_ff        <= S_IDLE;
			step_ff      <= 3'h0;
			wrCnt_ff     <= 3'h0;
			tmr_ff       <= 8'h00;
			busy_ff      <= 1'b0;
			byp_ff       <= 1'b0;
			tog_ff       <= 1'b0;
			rdData_ff    <= 16'h0000;
			cyc.reqValid <= 1'b0;
			cyc.reqWrite <= 1'b0;
			cyc.reqAddr  <= 20'h00000;
			cyc.reqData  <= 16'h0000;
		end else begin
			unique case (st_ff)
				S_IDLE: if (goPulse_ff) begin
					busy_ff  <= 1'b1;
					step_ff  <= 3'h0;
					wrCnt_ff <= 3'h0;
					st_ff    <= S_ISSUE;
				end
				S_ISSUE: if (cyc.ack) begin
					cyc.reqValid <= 1'b0;
					step_ff      <= step_ff + 3'h1;
					if (cyc.reqWrite) wrCnt_ff <= wrCnt_ff + 3'h1;
					if (seq[36]) begin
						if (op == OP_READ) rdData_ff <= cyc.rdData;
						if (op == OP_BYP_ON) byp_ff <= 1'b1;
						if (op == OP_BYP_OFF) byp_ff <= 1'b0;
						if (ctrlReg_ff[`BSFC_CTRL_WAIT] && isLong(op)) begin
							st_ff  <= ctrlReg_ff[`BSFC_CTRL_POLL] ? S_POLLA : S_SETTLE;
							tmr_ff <= BUSY_C;
						end else begin
							st_ff   <= S_IDLE;
							busy_ff <= 1'b0;
						end
					end
				end else if (!cyc.reqValid) begin
					cyc.reqValid <= 1'b1;
					cyc.reqWrite <= (op != OP_READ);
					cyc.reqAddr  <= seq[35:16];
					cyc.reqData  <= seq[15:0];
				end
				// Ready pin only means something after the device's busy delay
				S_SETTLE: if (tmr_ff == 8'h00) st_ff <= S_WPIN;
				else tmr_ff <= tmr_ff - 8'h01;
				S_WPIN: if (rdyLvl_ff) begin
					st_ff   <= S_IDLE;
					busy_ff <= 1'b0;
				end
				// Two reads in a row with equal flip bit mean the algorithm ended
				S_POLLA, S_POLLB: if (cyc.ack) begin
					cyc.reqValid <= 1'b0;
					tog_ff       <= cyc.rdData[6];
					if (st_ff == S_POLLA) st_ff <= S_POLLB;
					else if (cyc.rdData[6] == tog_ff) begin
						st_ff   <= S_IDLE;
						busy_ff <= 1'b0;
					end
				end else if (!cyc.reqValid) begin
					cyc.reqValid <= 1'b1;
					cyc.reqWrite <= 1'b0;
					cyc.reqAddr  <= addrReg_ff;
				end
			endcase
			// Pulsing the reset pin ends ready pin waits and bypass; bus cycles and toggle polls finish
			if (ctrlReg_ff[`BSFC_CTRL_HWRST]) begin
				byp_ff <= 1'b0;
				if (st_ff == S_SETTLE || st_ff == S_WPIN) begin
					st_ff   <= S_IDLE;
					busy_ff <= 1'b0;
				end
			end
		end
	end

	bsfc_cycle u_cycle (
		.sys_clk    (sys_clk),
		.reset      (reset),
		.cyc        (cyc.cyc),
		.flashCeN   (flashCeN),
		.flashOeN   (flashOeN),
		.flashWeN   (flashWeN),
		.flashAddr  (flashAddr),
		.dataBusOut (dataBusOut),
		.dataBusOeN (dataBusOeN),
		.dataBusIn  (dataBus)
	);

	property p_bypass_prog;
		@(posedge sys_clk) disable iff (reset)
		(st_ff == S_ISSUE && cyc.ack && seq[36] && op == OP_PROG) |->
			(wrCnt_ff == (byp_ff ? 3'd1 : 3'd3));
	endproperty
	a_bypass_prog: assert property (p_bypass_prog)
		else $error("program sequence has wrong number of writes");

	property p_pin_done;
		@(posedge sys_clk) disable iff (reset)
		$fell(st_ff == S_WPIN) |-> ($past(rdyLvl_ff) ||
			$past(ctrlReg_ff[`BSFC_CTRL_HWRST]));
	endproperty
	a_pin_done: assert property (p_pin_done)
		else $error("pin wait ended while device busy");

	property p_toggle_more;
		@(posedge sys_clk) disable iff (reset)
		(st_ff == S_POLLB && cyc.ack && cyc.rdData[6] != tog_ff) |=>
			(st_ff == S_POLLB && busy_ff);
	endproperty
	a_toggle_more: assert property (p_toggle_more)
		else $error("toggle poll ended while bit still flips");

	property p_suspend_code;
		@(posedge sys_clk) disable iff (reset)
		(st_ff == S_ISSUE && cyc.reqValid && op == OP_SUSP) |->
			(cyc.reqWrite && cyc.reqData[7:0] == `BSFC_CMD_SUSP);
	endproperty
	a_suspend_code: assert property (p_suspend_code)
		else $error("suspend not sent as its single write");

	property p_cmd_is_write;
		@(posedge sys_clk) disable iff (reset)
		(st_ff == S_ISSUE && $rose(cyc.reqValid) && op != OP_READ) |->
			cyc.reqWrite ##1 (cyc.reqValid && cyc.reqWrite);
	endproperty
	a_cmd_is_write: assert property (p_cmd_is_write)
		else $error("command step not issued as a write cycle");
endmodule

//--- bench/bsfc_flash_model.sv
// Behavioural flash device seen from the controller's pins
`timescale 1ns/1ps
module bsfc_flash_model (
	input  wire logic        clk,
	input  wire logic        ceN,
	input  wire logic        oeN,
	input  wire logic        weN,
	input  wire logic        resetN,
	input  wire logic [18:0] addr,
	input  wire logic [15:0] dOut,
	input  wire logic [15:0] dOeN,
	output logic      [15:0] dq,
	output logic             rdy
);
	logic [15:0] mem [256];
	logic [15:0] lst = 16'h0000;
	logic [15:0] wd = 16'h0000;
	logic [15:0] rd;
	logic [7:0]  bsy;
	logic [1:0]  ph;
	logic        wasW = 1'b0;
	logic        wasR = 1'b0;
	logic        tog = 1'b0;
	int          nw;
	int          lastNw = 0;
	initial for (int i = 0; i < 256; i++) mem[i] = 16'(i * 3);
	assign rdy = (bsy == 8'h00);
	// Status bits stand in for data while busy; released lines drift
	always_comb begin
		rd = (bsy != 8'h00) ? {8'h00, ~wd[7], tog, 6'h00} : mem[addr[7:0]];
		dq = (~dOeN & dOut) | (dOeN & ((!ceN && !oeN) ? rd : ~lst));
	end
	// Commands latched at the end of each write strobe
	always @(posedge clk) begin
		lst <= dq;
		wasW <= !ceN && !weN;
		wasR <= !ceN && !oeN;
		if (bsy != 8'h00)
			bsy <= bsy - 8'h01;
		if (wasR && oeN && bsy != 8'h00)
			tog <= ~tog;
		if (!resetN) begin
			ph <= 2'd0;
			bsy <= 8'h00;
			nw <= 0;
		end else if (wasW && weN) begin
			nw <= nw + 1;
			if (ph == 2'd1) begin
				mem[addr[7:0]] <= dOut;
				wd <= dOut;
				bsy <= 8'd40;
				ph <= 2'd0;
				lastNw <= nw + 1;
				nw <= 0;
			end else if (dOut[7:0] == 8'ha0)
				ph <= 2'd1;
			else if (dOut[7:0] == 8'h80)
				ph <= 2'd2;
			else if (ph == 2'd2 && dOut[7:0] == 8'h30) begin
				mem[addr[7:0]] <= 16'hffff;
				wd <= 16'hffff;
				bsy <= 8'd80;
				ph <= 2'd0;
				nw <= 0;
			end else if (dOut[7:0] == 8'h20 || dOut[7:0] == 8'h00)
				nw <= 0;
		end
	end
endmodule

//--- bench/bsfc_ctrl_test.sv
// Self-checking bench for the flash host controller
`timescale 1ns/1ps
module bsfc_ctrl_test;
	logic        sys_clk = 1'b0;
	logic        reset = 1'b1;
	logic [7:0]  awaddr = 8'h00;
	logic [7:0]  araddr = 8'h00;
	logic [31:0] wdata = 32'h0;
	logic        awvalid = 1'b0;
	logic        wvalid = 1'b0;
	logic        bready = 1'b0;
	logic        arvalid = 1'b0;
	logic        rready = 1'b0;
	logic        awready, wready, bvalid, arready, rvalid;
	logic        ceN, oeN, weN, rstN, rdy;
	logic [1:0]  rr;
	logic [31:0] rdata, st;
	logic [18:0] fa;
	logic [15:0] dOut, dOeN, dq;
	int          miscompares = 0;
	int          num_checks = 0;
	int          cyc = 0;
	always #4 sys_clk = ~sys_clk;
	bsfc_ctrl dut (.sys_clk(sys_clk), .reset(reset), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rr), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .flashCeN(ceN), .flashOeN(oeN), .flashWeN(weN),
		.flashResetN(rstN), .flashWordSel(), .flashAddr(fa),
		.dataBusOut(dOut), .dataBusOeN(dOeN), .dataBus(dq), .opDoneFlag(rdy));
	bsfc_flash_model fm (.clk(sys_clk), .ceN(ceN), .oeN(oeN), .weN(weN),
		.resetN(rstN), .addr(fa), .dOut(dOut), .dOeN(dOeN), .dq(dq), .rdy(rdy));
	task end_sim;
		if (miscompares == 0 && num_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("MISMATCH %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge sys_clk);
			if (awready === 1'b1) begin
				awvalid <= 1'b0;
				wvalid <= 1'b0;
			end
		end while (bvalid !== 1'b1);
		bready <= 1'b0;
	endtask
	task rd(input logic [7:0] a);
		@(posedge sys_clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge sys_clk);
			if (arready === 1'b1)
				arvalid <= 1'b0;
		end while (rvalid !== 1'b1);
		st = rdata;
		rready <= 1'b0;
	endtask
	// Load address and data, start, then poll status until idle
	task op(input logic [31:0] a, input logic [31:0] d, input logic [31:0] c);
		wr(8'h04, a);
		wr(8'h08, d);
		wr(8'h00, c);
		repeat (4) @(posedge sys_clk);
		do rd(8'h0c); while (st[0] !== 1'b0);
		// Done sets one edge after busy falls, so read status once more
		rd(8'h0c);
	endtask
	// Hang guard: sequence needs well under this many cycles
	always @(posedge sys_clk) begin
		cyc++;
		if (cyc > 30000) begin
			miscompares++;
			end_sim;
		end
	end
	initial begin
		repeat (2) @(posedge sys_clk);
		reset <= 1'b0;
		rd(8'h10);
		chk(rr, 2'b10);
		rd(8'h00);
		chk(st, 32'h20);
		op(32'h40, 0, 32'h21);
		chk(st[31:16], 16'h0060);
		op(32'h100, 32'h1234, 32'h33);
		chk(st[3:0], 4'ha);
		chk(fm.lastNw, 4);
		op(32'h100, 0, 32'h21);
		chk(st[31:16], 16'h1234);
		op(32'h200, 32'ha5c3, 32'h133);
		op(32'h200, 0, 32'h21);
		chk(st[31:16], 16'ha5c3);
		op(0, 0, 32'h2d);
		chk(st[2], 1'b1);
		op(32'h300, 32'h0f0f, 32'h33);
		chk(fm.lastNw, 2);
		op(0, 0, 32'h2f);
		chk(st[2], 1'b0);
		op(32'h100, 0, 32'h35);
		op(32'h100, 0, 32'h21);
		chk(st[31:16], 16'hffff);
		op(32'h200, 0, 32'h21);
		chk(st[31:16], 16'ha5c3);
		op(32'h100, 0, 32'h29);
		chk(st[3:0], 4'ha);
		op(32'h100, 0, 32'h2b);
		chk(st[3:0], 4'ha);
		wr(8'h00, 32'ha0);
		repeat (4) @(posedge sys_clk);
		chk(rstN, 1'b0);
		wr(8'h00, 32'h60);
		repeat (4) @(posedge sys_clk);
		chk(ceN, 1'b1);
		wr(8'h00, 32'h20);
		repeat (4) @(posedge sys_clk);
		chk({ceN, oeN, weN, rstN}, 4'h7);
		end_sim;
	end
endmodule
